// file: verilog/cis_chan_irq_id.sv
`timescale 1ns/10ps
`default_nettype none
module cis_chan_irq_id
	import cis_pkg::*;
#(
	parameter int SRC_W = 4,
	parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
	parameter logic [3:0] REV_CODE = 4'h3 // arbitrary value
)
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// parallel host port
	input wire logic host_cs_n_in,
	input wire logic host_rd_n_in,
	input wire logic host_wr_n_in,
	input wire logic [CIS_ADDR_W-1:0] host_addr_in,
	input wire logic [CIS_DATA_W-1:0] host_data_in,
	output logic [CIS_DATA_W-1:0] host_data_out,
	output logic host_data_oe_out,
	output logic host_irq_n_out,
	// source-level status and enables, same clock domain
	input wire logic [CIS_NUM_CHAN*SRC_W-1:0] src_status_in,
	input wire logic [CIS_NUM_CHAN*SRC_W-1:0] src_enable_in,
	// one-cycle pulse per channel when its source status is read
	output logic [CIS_NUM_CHAN-1:0] src_status_read_out
);
	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (SRC_W < 1 || SRC_W > CIS_DATA_W)
		$error("SRC_W must lie between 1 and the data width");
	// the summary and enable maps split the channels into two equal halves
	if (CIS_NUM_CHAN != 2 * CIS_CHAN_PER_REG)
		$error("channel count must fill both summary registers");
	// six channel bits plus the two reserved bits must fill one data word
	if (CIS_CHAN_PER_REG + $bits(CIS_RSVD_VALUE) != CIS_DATA_W)
		$error("summary layout does not fit the data width");

	// ----------------------------------------------------------------
	// host port synchroniser
	// ----------------------------------------------------------------
	// whole request is captured as one word so select, strobes and address age together
	cis_host_bus_t raw_req;
	cis_host_bus_t meta_q;
	cis_host_bus_t sync_q;
	logic rd_act_q;
	logic wr_act_q;
	wire rd_act;
	wire wr_act;
	wire rd_start;
	wire wr_start;

	// pins are active low; flip them once here so decode reads active high
	assign raw_req.sel = ~host_cs_n_in;
	assign raw_req.rd = ~host_rd_n_in;
	assign raw_req.wr = ~host_wr_n_in;
	assign raw_req.addr = host_addr_in;
	assign raw_req.wdata = host_data_in;

	// pins are asynchronous, so two stages before any decode
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= raw_req;
			sync_q <= meta_q;
		end
	end

	// strobe edge history, read only from the second stage
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rd_act_q <= 1'b0;
			wr_act_q <= 1'b0;
		end
		else
		begin
			rd_act_q <= rd_act;
			wr_act_q <= wr_act;
		end
	end

	// address and data must be stable before the strobe falls
	assign rd_act = sync_q.sel & sync_q.rd;
	assign wr_act = sync_q.sel & sync_q.wr;
	assign rd_start = rd_act & ~rd_act_q;
	assign wr_start = wr_act & ~wr_act_q;

	// ----------------------------------------------------------------
	// channel-level enables
	// ----------------------------------------------------------------
	logic [CIS_NUM_CHAN-1:0] chan_enable;
	wire hit_enable_lo;
	wire hit_enable_hi;

	// write decode looks at the synchronised address only
	assign hit_enable_lo = sync_q.addr == CIS_ADDR_ENABLE_LO;
	assign hit_enable_hi = sync_q.addr == CIS_ADDR_ENABLE_HI;

	// part and revision offsets have no write path at all
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			chan_enable <= {CIS_ENABLE_RESET, CIS_ENABLE_RESET};
		else if (wr_start && hit_enable_lo)
			chan_enable[CIS_CHAN_PER_REG-1:0] <= sync_q.wdata[CIS_CHAN_PER_REG-1:0];
		else if (wr_start && hit_enable_hi)
			chan_enable[CIS_NUM_CHAN-1:CIS_CHAN_PER_REG] <=
				sync_q.wdata[CIS_CHAN_PER_REG-1:0];
	end

	// ----------------------------------------------------------------
	// per-channel pending bits
	// ----------------------------------------------------------------
	// one sticky bit per channel, set by its enabled sources
	logic [CIS_NUM_CHAN-1:0] pending;
	logic [CIS_NUM_CHAN-1:0] src_read;

	for (genvar ch = 0; ch < CIS_NUM_CHAN; ch++)
	begin : g_chan
		// read of this channel's source status clears the summary bit
		assign src_read[ch] = rd_start && (sync_q.addr == cis_src_status_addr(ch));

		cis_chan_pending #(
			.SRC_W(SRC_W)
		) u_pending (
			.sys_clk_in(sys_clk_in),
			.rstn_in(rstn_in),
			.src_status_in(src_status_in[ch*SRC_W +: SRC_W]),
			.src_enable_in(src_enable_in[ch*SRC_W +: SRC_W]),
			.clear_in(src_read[ch]),
			.pending_out(pending[ch])
		);
	end

	// the source-level block clears its own status on this same pulse
	assign src_status_read_out = src_read;

	// ----------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------
	wire [CIS_DATA_W-1:0] pend_lo_word;
	wire [CIS_DATA_W-1:0] pend_hi_word;
	wire [CIS_DATA_W-1:0] enable_lo_word;
	wire [CIS_DATA_W-1:0] enable_hi_word;
	wire [CIS_DATA_W-1:0] revision_word;
	wire [CIS_DATA_W-1:0] read_word;

	// bits 7 and 6 of every summary and enable word read zero
	assign pend_lo_word = {CIS_RSVD_VALUE, pending[CIS_CHAN_PER_REG-1:0]};
	assign pend_hi_word = {CIS_RSVD_VALUE, pending[CIS_NUM_CHAN-1:CIS_CHAN_PER_REG]};
	assign enable_lo_word = {CIS_RSVD_VALUE, chan_enable[CIS_CHAN_PER_REG-1:0]};
	assign enable_hi_word = {CIS_RSVD_VALUE, chan_enable[CIS_NUM_CHAN-1:CIS_CHAN_PER_REG]};
	assign revision_word = {CIS_REV_UPPER, REV_CODE};

	// offsets owned by other blocks read as zero here
	assign read_word =
		(sync_q.addr == CIS_ADDR_PENDING_LO) ? pend_lo_word :
		(sync_q.addr == CIS_ADDR_PENDING_HI) ? pend_hi_word :
		(sync_q.addr == CIS_ADDR_ENABLE_LO) ? enable_lo_word :
		(sync_q.addr == CIS_ADDR_ENABLE_HI) ? enable_hi_word :
		(sync_q.addr == CIS_ADDR_PART_ID) ? PART_ID :
		(sync_q.addr == CIS_ADDR_REVISION) ? revision_word :
		CIS_UNMAPPED_READ;

	// ----------------------------------------------------------------
	// read data and interrupt pin
	// ----------------------------------------------------------------
	// read data register and interrupt pin state
	logic [CIS_DATA_W-1:0] rdata;
	logic irq_n;
	wire irq_any;

	// only channels enabled at channel level reach the pin
	assign irq_any = |(pending & chan_enable);

	// data is captured once per read, so a bit that clears mid-read
	// does not change the value the host is latching
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			rdata <= CIS_UNMAPPED_READ;
		else if (rd_start)
			rdata <= read_word;
	end

	// registered so the pin never glitches while bits and enables move
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			irq_n <= 1'b1;
		else
			irq_n <= ~irq_any;
	end

	// the host owns the data bus except while a read is answered
	assign host_data_out = rdata;
	assign host_data_oe_out = rd_act & rd_act_q; // drive once rdata is valid
	assign host_irq_n_out = irq_n;
endmodule // cis_chan_irq_id
`default_nettype wire

// file: verilog/cis_pkg.sv
`default_nettype none
package cis_pkg;
	// ----------------------------------------------------------------
	// map geometry
	// ----------------------------------------------------------------
	localparam int CIS_NUM_CHAN = 12;
	localparam int CIS_CHAN_PER_REG = 6;
	localparam int CIS_ADDR_W = 8;
	localparam int CIS_DATA_W = 8;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CIS_ADDR_ENABLE_LO = 8'h60;
	localparam logic [7:0] CIS_ADDR_PENDING_LO = 8'h61;
	localparam logic [7:0] CIS_ADDR_ENABLE_HI = 8'he0;
	localparam logic [7:0] CIS_ADDR_PENDING_HI = 8'he1;
	localparam logic [7:0] CIS_ADDR_PART_ID = 8'h6e;
	localparam logic [7:0] CIS_ADDR_REVISION = 8'h6f;
	// source-level status sits at row m, column 2
	localparam logic [3:0] CIS_SRC_STATUS_COL = 4'h2;
	// upper channels start at row 8, i.e. channel 6 plus 2
	localparam logic [3:0] CIS_UPPER_ROW_SKIP = 4'h2;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int CIS_CHAN_FIELD_LSB = 0;
	localparam logic [1:0] CIS_RSVD_VALUE = 2'h0;
	localparam logic [3:0] CIS_REV_UPPER = 4'h0;
	localparam logic [5:0] CIS_ENABLE_RESET = 6'h00;
	localparam logic [7:0] CIS_UNMAPPED_READ = 8'h00;

	// host port signals after polarity fix, all active high
	typedef struct packed {
		logic sel;
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cis_host_bus_t;

	// address of the source-level status register of one channel
	function automatic logic [7:0] cis_src_status_addr(input int ch);
		logic [3:0] row;
		row = 4'(ch);
		if (ch >= CIS_CHAN_PER_REG)
			row = 4'(ch) + CIS_UPPER_ROW_SKIP;
		return {row, CIS_SRC_STATUS_COL};
	endfunction
endpackage
`default_nettype wire

// file: verilog/cis_chan_pending.sv
`timescale 1ns/10ps
`default_nettype none
module cis_chan_pending
	import cis_pkg::*;
#(
	parameter int SRC_W = 4
)
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [SRC_W-1:0] src_status_in,
	input wire logic [SRC_W-1:0] src_enable_in,
	input wire logic clear_in,
	output logic pending_out
);
	// an empty source field would leave the channel bit stuck at zero
	if (SRC_W < 1)
		$error("SRC_W must be at least 1");

	// ----------------------------------------------------------------
	// per-channel sticky pending bit
	// ----------------------------------------------------------------
	logic pending;
	logic raise;

	// any enabled source cause raises the channel
	assign raise = |(src_status_in & src_enable_in);

	// raise wins over a clear in the same cycle so no event is dropped
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			pending <= 1'b0;
		else if (raise)
			pending <= 1'b1;
		else if (clear_in)
			pending <= 1'b0;
	end

	assign pending_out = pending;
endmodule // cis_chan_pending
`default_nettype wire

// file: tb/cis_chan_irq_id_props.sv
`timescale 1ns/10ps
`default_nettype none
module cis_chan_irq_id_props
	import cis_pkg::*;
#(
	parameter int SRC_W = 4,
	parameter logic [7:0] PART_ID = 8'h5a,
	parameter logic [3:0] REV_CODE = 4'h3
)
(
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic host_cs_n_in,
	input wire logic host_rd_n_in,
	input wire logic host_wr_n_in,
	input wire logic [CIS_ADDR_W-1:0] host_addr_in,
	input wire logic [CIS_DATA_W-1:0] host_data_in,
	input wire logic [CIS_DATA_W-1:0] host_data_out,
	input wire logic host_data_oe_out,
	input wire logic host_irq_n_out,
	input wire logic [CIS_NUM_CHAN*SRC_W-1:0] src_status_in,
	input wire logic [CIS_NUM_CHAN*SRC_W-1:0] src_enable_in,
	input wire logic [CIS_NUM_CHAN-1:0] src_status_read_out
);
	// ----------------------------------------------------------------
	// read answers, three edges behind the pins
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	a_part_id_fixed: assert property (
		$rose(host_data_oe_out) && $past(host_addr_in, 3) == 8'h6e
		|-> host_data_out == PART_ID) else $error("part id read wrong");
	a_revision_code: assert property (
		$rose(host_data_oe_out) && $past(host_addr_in, 3) == 8'h6f
		|-> host_data_out == {4'h0, REV_CODE}) else $error("revision read wrong");
	a_reserved_bits_zero: assert property (
		$rose(host_data_oe_out) && $past(host_addr_in[6:0], 3) == 7'h61
		|-> host_data_out[7:6] == 2'h0) else $error("summary reserved bits set");
	a_oe_needs_read: assert property (
		host_data_oe_out |-> !$past(host_rd_n_in, 3) && !$past(host_cs_n_in, 3))
		else $error("bus driven unasked");
	a_data_holds: assert property (
		host_data_oe_out && $past(host_data_oe_out) |-> $stable(host_data_out))
		else $error("read data moved");
	// ----------------------------------------------------------------
	// clear pulses come only from a source status read
	// ----------------------------------------------------------------
	a_clear_needs_read: assert property (
		src_status_read_out != 12'h000
		|-> $past(host_addr_in[3:0], 2) == 4'h2 && !$past(host_rd_n_in, 2)
		&& !$past(host_cs_n_in, 2)) else $error("clear without read");
	a_clear_one_cycle: assert property (
		src_status_read_out != 12'h000 |=> src_status_read_out == 12'h000)
		else $error("clear pulse too long");
	a_clear_one_chan: assert property ($onehot0(src_status_read_out))
		else $error("clear hit two channels");
endmodule // cis_chan_irq_id_props
`default_nettype wire

// file: tb/cis_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cis_host_model
(
	input wire logic sys_clk_in,
	output logic cs_n_out,
	output logic rd_n_out,
	output logic wr_n_out,
	output logic [7:0] addr_out,
	output logic [7:0] data_out
);
	initial
	begin
		{cs_n_out, rd_n_out, wr_n_out} = 3'h7;
		addr_out = 8'h00;
		data_out = 8'h00;
	end
	// one access: address settles 2 clocks early, strobe low 5, high 4
	// a read leaves the inverse on our data lines so stale data never matches
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		#1;
		addr_out = a;
		data_out = wr ? d : ~d;
		repeat (2) @(posedge sys_clk_in);
		#1;
		cs_n_out = 1'b0;
		rd_n_out = wr;
		wr_n_out = !wr;
		repeat (5) @(posedge sys_clk_in);
		#1;
		{cs_n_out, rd_n_out, wr_n_out} = 3'h7;
		repeat (4) @(posedge sys_clk_in);
		#1;
	endtask
endmodule // cis_host_model
`default_nettype wire

// file: tb/cis_chan_irq_id_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cis_chan_irq_id_tb
	import cis_pkg::*;
;
	localparam int SRC_W = 4;
	localparam logic [7:0] PART_ID = 8'h5a; // arbitrary value
	localparam logic [3:0] REV_CODE = 4'h3; // arbitrary value
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic host_cs_n_in, host_rd_n_in, host_wr_n_in, host_data_oe_out, host_irq_n_out;
	logic [7:0] host_addr_in, host_data_in, host_data_out;
	logic [CIS_NUM_CHAN*SRC_W-1:0] src_status_in = '0;
	logic [CIS_NUM_CHAN*SRC_W-1:0] src_enable_in = '0;
	logic [CIS_NUM_CHAN-1:0] src_status_read_out;
	logic [7:0] exp_q[$];
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	always #5 sys_clk_in = ~sys_clk_in;
	logic oe_was = 1'b0;
	logic [7:0] clr_ch = 8'hff;
	int n_clr = 0;
	cis_chan_irq_id #(.SRC_W(SRC_W), .PART_ID(PART_ID), .REV_CODE(REV_CODE)) i_dut (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.host_cs_n_in(host_cs_n_in),
		.host_rd_n_in(host_rd_n_in),
		.host_wr_n_in(host_wr_n_in),
		.host_addr_in(host_addr_in),
		.host_data_in(host_data_in),
		.host_data_out(host_data_out),
		.host_data_oe_out(host_data_oe_out),
		.host_irq_n_out(host_irq_n_out),
		.src_status_in(src_status_in),
		.src_enable_in(src_enable_in),
		.src_status_read_out(src_status_read_out)
	);
	cis_host_model i_host (.sys_clk_in(sys_clk_in), .cs_n_out(host_cs_n_in),
		.rd_n_out(host_rd_n_in), .wr_n_out(host_wr_n_in), .addr_out(host_addr_in),
		.data_out(host_data_in));
	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("counts: %0d compared, %0d mismatches", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.acc(1'b0, a, 8'h00);
	endtask
	// look half a cycle after the enable rises, when data and enable have settled
	always @(negedge sys_clk_in)
	begin
		if (host_data_oe_out && !oe_was)
			chk("read data", host_data_out, exp_q.pop_front());
		oe_was = host_data_oe_out;
	end
	// note which channel each source status read clears, and how many clears came
	always @(negedge sys_clk_in)
	begin
		for (int i = 0; i < CIS_NUM_CHAN; i++)
		begin
			if (src_status_read_out[i])
			begin
				clr_ch = 8'(i);
				n_clr++;
			end
		end
	end
	// a hang is cut short well past the expected run length
	always @(posedge sys_clk_in)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			end_sim();
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic hi;
		logic [5:0] b;
		logic [7:0] sum, en;
		logic [3:0] src;
		void'($urandom(32'hd693f3a2));
		repeat (10) @(posedge sys_clk_in);
		#1 rstn_in = 1'b1;
		rd(CIS_ADDR_PART_ID, PART_ID);
		i_host.acc(1'b1, CIS_ADDR_PART_ID, 8'($urandom));
		rd(CIS_ADDR_PART_ID, PART_ID);
		rd(CIS_ADDR_REVISION, {4'h0, REV_CODE});
		rd(8'h70, CIS_UNMAPPED_READ);
		$display("identity test done");
		for (int ch = 0; ch < CIS_NUM_CHAN; ch++)
		begin
			hi = ch >= 6;
			b = 6'(1 << (ch % 6));
			sum = hi ? CIS_ADDR_PENDING_HI : CIS_ADDR_PENDING_LO;
			en = hi ? CIS_ADDR_ENABLE_HI : CIS_ADDR_ENABLE_LO;
			src = 4'($urandom_range(15, 1));
			// disabled sources alone must not raise the channel
			src_enable_in = {{(CIS_NUM_CHAN - 1) * SRC_W{1'b0}}, src} << (ch * SRC_W);
			src_status_in[ch*SRC_W +: SRC_W] = 4'($urandom) & ~src;
			i_host.acc(1'b1, en, {2'h0, b});
			rd(sum, 8'h00);
			chk("irq idle", {7'h0, host_irq_n_out}, 8'h01);
			src_status_in[ch*SRC_W +: SRC_W] |= src;
			rd(sum, {2'h0, b});
			chk("irq raised", {7'h0, host_irq_n_out}, 8'h00);
			i_host.acc(1'b1, en, 8'h00);
			chk("irq masked", {7'h0, host_irq_n_out}, 8'h01);
			src_status_in[ch*SRC_W +: SRC_W] = '0;
			rd(sum, {2'h0, b});
			rd({4'(hi ? ch + 2 : ch), 4'h2}, CIS_UNMAPPED_READ);
			chk("clear channel", clr_ch, 8'(ch));
			chk("clear count", 8'(n_clr), 8'(ch + 1));
			rd(sum, 8'h00);
		end
		$display("channel pending test done");
		end_sim();
	end
endmodule // cis_chan_irq_id_tb
bind cis_chan_irq_id cis_chan_irq_id_props #(.SRC_W(SRC_W), .PART_ID(PART_ID),
	.REV_CODE(REV_CODE)) i_props (
	.sys_clk_in(sys_clk_in),
	.rstn_in(rstn_in),
	.host_cs_n_in(host_cs_n_in),
	.host_rd_n_in(host_rd_n_in),
	.host_wr_n_in(host_wr_n_in),
	.host_addr_in(host_addr_in),
	.host_data_in(host_data_in),
	.host_data_out(host_data_out),
	.host_data_oe_out(host_data_oe_out),
	.host_irq_n_out(host_irq_n_out),
	.src_status_in(src_status_in),
	.src_enable_in(src_enable_in),
	.src_status_read_out(src_status_read_out)
);
`default_nettype wire
